// ---- rtl/crt_timer.sv ----
// Capture / reload timer-counter with AXI4-Lite register access
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
module crt_timer
(
   // Clock and reset
   input logic aclk,
   input logic aresetn,
   // AXI4-Lite write channels
   input logic [7:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [31:0] s_axi_wdata,
   input logic [3:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   // AXI4-Lite read channels
   input logic [7:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   // Shared count input / clock output pin
   input logic count_pin_i,
   output logic count_pin_o,
   output logic count_pin_oe,
   // Trigger and direction pin
   input logic trigger_pin_i,
   // Interrupts
   output logic timer_req,
   output logic irq
);
   import crt_pkg::*;

   // Next count value one step up or down
   function automatic logic [15:0] crt_step(input logic [15:0] v, input logic down);
      crt_step = down ? v - 16'h0001 : v + 16'h0001;
   endfunction

   // True for an offset that holds a register
   function automatic logic crt_mapped(input logic [7:0] a);
      crt_mapped = (a <= CRT_OFF_IRQ_MASK) && (a[1:0] == 2'h0);
   endfunction

   crt_ctrl_t ctrl; // Timer control register
   crt_mode_t mode; // Timer mode register
   logic [15:0] count; // Count, high and low byte
   logic [15:0] cap; // Capture / reload bytes
   logic [1:0] irq_stat; // Sticky interrupt status
   logic [1:0] irq_mask; // Interrupt mask
   logic [3:0] phase; // Position within the machine cycle
   logic half; // Half-rate enable for fast modes
   logic cnt_lvl, trg_lvl; // Synchronised pin levels
   logic cnt_smp, trg_smp; // Levels taken at the sample phase
   logic cnt_fall; // Fall seen, held over the next machine cycle
   logic trg_fall; // One-cycle strobe of a trigger fall
   logic step_q, wrap_q, down_q; // Step decided at the flag phase
   logic clk_out; // Clock-out level
   crt_pin_drive_t drive; // Pin drive pair
   logic aw_hold, w_hold; // Write address / data taken
   logic [7:0] aw_addr; // Held write address
   logic [31:0] w_data; // Held write data
   logic [3:0] w_strb; // Held write strobes
   logic do_wr; // Both halves present, commit now
   logic wr_en; // Commit touching the low byte lane
   logic [31:0] rd_mux; // Read data for the offered address

   // Mode decode
   logic baud, fast, reload_mode, capture_mode, count_down, slow_step, wrap_now;
   logic hw_ovf, hw_exf, trig_reload, trig_capture;

   assign baud = ctrl.receive_baud_select | ctrl.transmit_baud_select;
   assign fast = ctrl.run_bit & ~ctrl.counter_timer_select
      & (baud | mode.clock_output_enable);
   assign reload_mode = ctrl.run_bit & ~baud & ~ctrl.capture_reload_select;
   assign capture_mode = ctrl.run_bit & ~baud & ctrl.capture_reload_select;
   // Trigger pin low selects down counting when enabled
   assign count_down = reload_mode & mode.down_count_enable & ~trg_lvl;
   // Timer steps each machine cycle, counter only on a seen fall
   assign slow_step = ctrl.run_bit & ~fast
      & (ctrl.counter_timer_select ? cnt_fall : 1'b1);
   assign wrap_now = count_down ? (count == cap) : (count == CRT_CNT_MAX);
   // Overflow flag is not raised while generating baud or clock
   assign hw_ovf = (phase == CRT_PH_FLAG) & slow_step & wrap_now & ~baud;
   assign trg_fall = (phase == CRT_PH_SAMPLE) & trg_smp & ~trg_lvl;
   // Direction mode uses the trigger as a level, not an edge
   assign hw_exf = trg_fall & ctrl.external_enable_bit
      & ~(reload_mode & mode.down_count_enable);
   assign trig_reload = trg_fall & reload_mode & ctrl.external_enable_bit
      & ~mode.down_count_enable;
   assign trig_capture = trg_fall & capture_mode & ctrl.external_enable_bit;

   // Pin synchronisers
   crt_pin_sync u_cnt_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_i(count_pin_i),
      .level_o(cnt_lvl)
   );
   crt_pin_sync u_trg_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_i(trigger_pin_i),
      .level_o(trg_lvl)
   );

   // Machine cycle of twelve clocks
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         phase <= 4'h0;
      else if (phase == CRT_PH_LAST)
         phase <= 4'h0;
      else
         phase <= phase + 4'h1;
   end

   // Half-rate enable for baud and clock-out counting
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         half <= 1'b0;
      else
         half <= ~half;
   end

   // Pin samples once per machine cycle; a fall needs two samples
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_smp <= 1'b0;
         trg_smp <= 1'b0;
         cnt_fall <= 1'b0;
      end
      else if (phase == CRT_PH_SAMPLE)
      begin
         cnt_smp <= cnt_lvl;
         trg_smp <= trg_lvl;
         cnt_fall <= cnt_smp & ~cnt_lvl;
      end
   end

   // Step decision taken at the flag phase, applied one clock later
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         step_q <= 1'b0;
         wrap_q <= 1'b0;
         down_q <= 1'b0;
      end
      else if (phase == CRT_PH_FLAG)
      begin
         step_q <= slow_step;
         wrap_q <= wrap_now;
         down_q <= count_down;
      end
   end

   // Count: software write, trigger reload, machine step, fast step
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count <= CRT_CNT_RST;
      else if (wr_en && aw_addr == CRT_OFF_CNT_LO)
         count[7:0] <= w_data[7:0];
      else if (wr_en && aw_addr == CRT_OFF_CNT_HI)
         count[15:8] <= w_data[7:0];
      else if (trig_reload)
         count <= cap;
      else if (phase == CRT_PH_UPDATE && step_q && ctrl.run_bit) // stop cancels late step
      begin
         // Visible at the update phase after the counted fall
         if (!wrap_q)
            count <= crt_step(count, down_q);
         else if (down_q)
            count <= CRT_CNT_MAX;
         else if (capture_mode)
            count <= CRT_CNT_ZERO;
         else
            count <= cap;
      end
      else if (fast && half)
         count <= (count == CRT_CNT_MAX) ? cap : crt_step(count, 1'b0);
   end

   // Capture bytes; hardware capture yields to a software write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cap <= CRT_CAP_RST;
      else if (wr_en && aw_addr == CRT_OFF_CAP_LO)
         cap[7:0] <= w_data[7:0];
      else if (wr_en && aw_addr == CRT_OFF_CAP_HI)
         cap[15:8] <= w_data[7:0];
      else if (trig_capture)
         cap <= count;
   end

   // Clock-out toggles on each fast rollover, giving a 50% duty output
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clk_out <= 1'b0;
      else if (fast && half && mode.clock_output_enable && count == CRT_CNT_MAX)
         clk_out <= ~clk_out;
   end

   // The count pin is driven only while clock-out is selected
   assign drive.level = clk_out;
   assign drive.enable = mode.clock_output_enable & ~ctrl.counter_timer_select;
   assign count_pin_o = drive.level;
   assign count_pin_oe = drive.enable;

   // Control register; a hardware set wins over a software clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl <= crt_ctrl_t'(CRT_CTRL_RST);
      else
      begin
         if (wr_en && aw_addr == CRT_OFF_CTRL)
            ctrl <= crt_ctrl_t'(w_data[7:0]);
         if (hw_ovf)
            ctrl.overflow_flag <= 1'b1;
         if (hw_exf)
            ctrl.external_event_flag <= 1'b1;
      end
   end

   // Mode register; down counting is off after reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode <= crt_mode_t'(CRT_MODE_RST);
      else if (wr_en && aw_addr == CRT_OFF_MODE)
         mode <= crt_mode_t'({6'h00, w_data[1:0]});
   end

   // Sticky interrupt status, write one to clear, set wins
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_stat <= CRT_IRQ_RST;
      else
      begin
         if (wr_en && aw_addr == CRT_OFF_IRQ_STAT)
            irq_stat <= irq_stat & ~w_data[1:0];
         if (hw_ovf)
            irq_stat[CRT_IRQ_OVF] <= 1'b1;
         if (hw_exf)
            irq_stat[CRT_IRQ_EXF] <= 1'b1;
      end
   end

   // Interrupt mask
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_mask <= CRT_IRQ_RST;
      else if (wr_en && aw_addr == CRT_OFF_IRQ_MASK)
         irq_mask <= w_data[1:0];
   end

   // Flags stay until software clears them
   assign timer_req = ctrl.overflow_flag | ctrl.external_event_flag;
   assign irq = |(irq_stat & irq_mask);

   // Write address and data are taken independently
   assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
   assign do_wr = aw_hold & w_hold & ~s_axi_bvalid;
   // Byte lane zero carries every register
   assign wr_en = do_wr & w_strb[0] & crt_mapped(aw_addr);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CRT_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_wr)
         begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= crt_mapped(aw_addr) ? CRT_RESP_OKAY : CRT_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Read decode; unused bits read as zero
   always_comb
   begin
      rd_mux = 32'h00000000;
      if (s_axi_araddr == CRT_OFF_CTRL)
         rd_mux[7:0] = ctrl;
      else if (s_axi_araddr == CRT_OFF_MODE)
         rd_mux[7:0] = mode;
      else if (s_axi_araddr == CRT_OFF_CNT_LO)
         rd_mux[7:0] = count[7:0];
      else if (s_axi_araddr == CRT_OFF_CNT_HI)
         rd_mux[7:0] = count[15:8];
      else if (s_axi_araddr == CRT_OFF_CAP_LO)
         rd_mux[7:0] = cap[7:0];
      else if (s_axi_araddr == CRT_OFF_CAP_HI)
         rd_mux[7:0] = cap[15:8];
      else if (s_axi_araddr == CRT_OFF_IRQ_STAT)
         rd_mux[1:0] = irq_stat;
      else if (s_axi_araddr == CRT_OFF_IRQ_MASK)
         rd_mux[1:0] = irq_mask;
   end

   // Read answer one clock after the address is taken
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= CRT_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= crt_mapped(s_axi_araddr) ? CRT_RESP_OKAY : CRT_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_phase_wraps: assert property (phase == CRT_PH_LAST |=> phase == 4'h0)
      else $error("machine cycle not twelve clocks");
   a_step_spacing: assert property ((phase == CRT_PH_SAMPLE && cnt_fall)
      |-> ##12 !cnt_fall)
      else $error("counted falls closer than two cycles");
   a_count_phase: assert property (($past(aresetn) && !$past(do_wr) && !$past(fast)
      && !$past(trg_fall) && count != $past(count)) |-> $past(phase) == CRT_PH_UPDATE)
      else $error("count moved outside update phase");
   a_ovf_phase: assert property ($rose(ctrl.overflow_flag) && !$past(do_wr)
      |-> $past(phase) == CRT_PH_FLAG)
      else $error("overflow flag set at wrong phase");
   a_capture_copy: assert property (trig_capture && !do_wr |=> cap == $past(count))
      else $error("capture bytes not loaded");
   a_exf_set: assert property (hw_exf |=> ctrl.external_event_flag)
      else $error("external event flag missed");
   a_req_kept: assert property (timer_req && !do_wr |=> timer_req)
      else $error("request dropped without software");
   a_down_reset: assert property (!$past(aresetn) |-> !mode.down_count_enable)
      else $error("down enable not clear after reset");
   a_off_hold: assert property (!ctrl.run_bit && !do_wr && !trg_fall |=> count == $past(count))
      else $error("stopped counter moved");
   a_fast_noflag: assert property (fast && ctrl.run_bit && !do_wr |=> !$rose(ctrl.overflow_flag))
      else $error("overflow flag in clock-out mode");
   a_sw_clear: assert property ((wr_en && aw_addr == CRT_OFF_CTRL && !w_data[7] && !hw_ovf)
      |=> !ctrl.overflow_flag && ctrl.run_bit == $past(w_data[2]))
      else $error("flag write not taken");

   c_overflow: cover property (hw_ovf);
   c_capture: cover property (trig_capture);
   c_clock_out: cover property (fast && $changed(clk_out));
   c_down: cover property (phase == CRT_PH_UPDATE && step_q && down_q);
endmodule // crt_timer

// ---- shared/crt_pkg.sv ----
package crt_pkg;
   // Register byte offsets on the AXI4-Lite bus
   localparam logic [7:0] CRT_OFF_CTRL = 8'h00;
   localparam logic [7:0] CRT_OFF_MODE = 8'h04;
   localparam logic [7:0] CRT_OFF_CNT_LO = 8'h08;
   localparam logic [7:0] CRT_OFF_CNT_HI = 8'h0C;
   localparam logic [7:0] CRT_OFF_CAP_LO = 8'h10;
   localparam logic [7:0] CRT_OFF_CAP_HI = 8'h14;
   localparam logic [7:0] CRT_OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] CRT_OFF_IRQ_MASK = 8'h1C;
   // Machine cycle phases, counted in core clocks
   localparam logic [3:0] CRT_PH_FLAG = 4'h3;
   localparam logic [3:0] CRT_PH_UPDATE = 4'h4;
   localparam logic [3:0] CRT_PH_SAMPLE = 4'h9;
   localparam logic [3:0] CRT_PH_LAST = 4'hB;
   // Values after reset
   localparam logic [7:0] CRT_CTRL_RST = 8'h00;
   localparam logic [7:0] CRT_MODE_RST = 8'h00;
   localparam logic [15:0] CRT_CNT_RST = 16'h0000;
   localparam logic [15:0] CRT_CAP_RST = 16'h0000;
   localparam logic [1:0] CRT_IRQ_RST = 2'h0;
   // Count limits
   localparam logic [15:0] CRT_CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CRT_CNT_ZERO = 16'h0000;
   // Interrupt status bit positions
   localparam int CRT_IRQ_OVF = 0;
   localparam int CRT_IRQ_EXF = 1;
   // Bus responses
   localparam logic [1:0] CRT_RESP_OKAY = 2'h0;
   localparam logic [1:0] CRT_RESP_SLVERR = 2'h2;

   // Timer control register layout
   typedef struct packed {
      logic overflow_flag;
      logic external_event_flag;
      logic receive_baud_select;
      logic transmit_baud_select;
      logic external_enable_bit;
      logic run_bit;
      logic counter_timer_select;
      logic capture_reload_select;
   } crt_ctrl_t;

   // Timer mode register layout
   typedef struct packed {
      logic [5:0] unused;
      logic clock_output_enable;
      logic down_count_enable;
   } crt_mode_t;

   // Drive of the shared count / clock-out pin
   typedef struct packed {
      logic level;
      logic enable;
   } crt_pin_drive_t;
endpackage

// ---- rtl/crt_pin_sync.sv ----
// Two-flop synchroniser for a pin input
module crt_pin_sync
(
   // Clock and reset
   input logic aclk,
   input logic aresetn,
   // Pin and synchronised level
   input logic pin_i,
   output logic level_o
);
   import crt_pkg::*;

   logic meta; // First stage, read only by the second

   // Pins are asynchronous to the core clock
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= 1'b1;
         level_o <= 1'b1;
      end
      else
      begin
         meta <= pin_i;
         level_o <= meta;
      end
   end
endmodule // crt_pin_sync

// ---- dv/crt_pin_model.sv ----
// External source on the count pin and the trigger / direction pin
module crt_pin_model
(
   // Clock
   input wire logic aclk,
   // Design side of the shared count / clock-out pin
   input wire logic count_pin_o,
   input wire logic count_pin_oe,
   // Resolved pin levels seen by the design
   output logic count_line,
   output logic trigger_line
);
   timeunit 1ns;
   timeprecision 1ns;
   // One machine cycle plus the two synchroniser flops
   localparam int HOLD = 14;
   logic count_drv; // Level the external source puts on the count pin
   // Both pins idle high through the port pull-ups
   initial
   begin
      count_drv = 1'b1;
      trigger_line = 1'b1;
   end
   // The design owns the shared pin while its clock output is enabled
   assign count_line = count_pin_oe ? count_pin_o : count_drv;
   // Each level is held long enough to be sampled at least once
   task automatic hold_level();
      repeat (HOLD) @(posedge aclk);
   endtask
   // Send n falling edges on the count pin, never faster than allowed
   task automatic pulse_count(input int n);
      repeat (n)
      begin
         count_drv <= 1'b0;
         hold_level();
         count_drv <= 1'b1;
         hold_level();
      end
   endtask
   // Set the direction level on the trigger pin
   task automatic trig_level(input logic v);
      trigger_line <= v;
      hold_level();
   endtask
   // One falling edge on the trigger pin, back to idle high after
   task automatic trig_fall();
      trig_level(1'b0);
      trig_level(1'b1);
   endtask
endmodule // crt_pin_model

// ---- dv/tb_top.sv ----
// Bench for the capture / reload timer-counter
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import crt_pkg::*;
   // Expected read answer; chk low when the data cannot be known ahead
   typedef struct packed {logic [31:0] d; logic [1:0] r; logic chk;} crt_rexp_t;
   localparam int LIMIT = 20000; // The run needs about 1500 cycles
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, count_line, trigger_line;
   logic count_pin_o, count_pin_oe, timer_req, irq;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv, r;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] seed = 32'h000114C6;
   logic [1:0] wq [$]; // Expected write responses, oldest first
   crt_rexp_t rq [$]; // Expected read answers, oldest first
   crt_rexp_t re;
   int bad_count = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [7:0] offs [8] = '{CRT_OFF_CTRL, CRT_OFF_MODE, CRT_OFF_CNT_LO, CRT_OFF_CNT_HI,
      CRT_OFF_CAP_LO, CRT_OFF_CAP_HI, CRT_OFF_IRQ_STAT, CRT_OFF_IRQ_MASK};
   // Device under test
   crt_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .count_pin_i(count_line), .count_pin_o(count_pin_o),
      .count_pin_oe(count_pin_oe), .trigger_pin_i(trigger_line), .timer_req(timer_req),
      .irq(irq));
   // Far side of the pins
   crt_pin_model i_pins (.aclk(aclk), .count_pin_o(count_pin_o),
      .count_pin_oe(count_pin_oe), .count_line(count_line), .trigger_line(trigger_line));
   // Clock, 100 ns period
   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // Random source with a fixed start
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Compare one value and count it
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Verdict and end of run
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
      begin
         $display("TEST PASSED");
      end
      else
      begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Ready is checked mid-cycle, where it is settled, so the edge decides nothing
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic hit_aw, hit_w, hit_b;
      hit_b = 1'b0;
      wq.push_back(er);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!hit_b)
      begin
         @(negedge aclk);
         hit_aw = s_axi_awvalid && s_axi_awready;
         hit_w = s_axi_wvalid && s_axi_wready;
         hit_b = s_axi_bvalid && s_axi_bready;
         @(posedge aclk);
         if (hit_aw) s_axi_awvalid <= 1'b0;
         if (hit_w) s_axi_wvalid <= 1'b0;
      end
   endtask
   // Read one register; the monitor compares the answer
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er,
      input logic c, output logic [31:0] got);
      logic hit_ar, hit_r;
      hit_r = 1'b0;
      rq.push_back(crt_rexp_t'{ed, er, c});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!hit_r)
      begin
         @(negedge aclk);
         hit_ar = s_axi_arvalid && s_axi_arready;
         hit_r = s_axi_rvalid && s_axi_rready;
         got = s_axi_rdata;
         @(posedge aclk);
         if (hit_ar) s_axi_arvalid <= 1'b0;
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] ed);
      rd(a, {24'h0, ed}, CRT_RESP_OKAY, 1'b1, rv);
   endtask
   task automatic wrc(input logic [7:0] a, input logic [7:0] d);
      wr(a, {24'h0, d}, CRT_RESP_OKAY);
   endtask
   // Count progress over exactly ten machine cycles, both reads in the same phase
   task automatic delta(input logic [7:0] exp);
      logic [31:0] a, b;
      int t;
      t = cyc;
      rd(CRT_OFF_CNT_LO, 32'h0, CRT_RESP_OKAY, 1'b0, a);
      while (cyc < t + 120) @(posedge aclk);
      rd(CRT_OFF_CNT_LO, 32'h0, CRT_RESP_OKAY, 1'b0, b);
      check("count_step", {24'h0, exp}, {24'h0, b[7:0] - a[7:0]});
   endtask
   // Response monitor: handshakes land at the next rising edge
   always @(negedge aclk)
   begin
      if (s_axi_bvalid && s_axi_bready)
      begin
         check("bresp", {30'h0, wq.pop_front()}, {30'h0, s_axi_bresp});
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
         re = rq.pop_front();
         check("rresp", {30'h0, re.r}, {30'h0, s_axi_rresp});
         if (re.chk) check("rdata", re.d, s_axi_rdata);
      end
   end
   // Cycle count and hang guard
   always @(negedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         bad_count++;
         finish_test();
      end
   end
   // Main sequence
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b1; // Both answer channels are always accepted
      s_axi_rready = 1'b1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      foreach (offs[i]) rdc(offs[i], 8'h00);
      rd(8'h20, 32'h0, CRT_RESP_SLVERR, 1'b1, rv);
      wr(8'h22, 32'h1, CRT_RESP_SLVERR);
      r = xs();
      wrc(CRT_OFF_CAP_LO, r[7:0]);
      wrc(CRT_OFF_CAP_HI, r[15:8]);
      rdc(CRT_OFF_CAP_LO, r[7:0]);
      rdc(CRT_OFF_CAP_HI, r[15:8]);
      // Stopped, then running as a timer
      wrc(CRT_OFF_CTRL, 8'h01);
      delta(8'h00);
      wrc(CRT_OFF_CTRL, 8'h05);
      delta(8'h0A);
      // Overflow in capture mode, flags and interrupt path
      wrc(CRT_OFF_CTRL, 8'h01);
      wrc(CRT_OFF_CNT_HI, 8'hFF);
      wrc(CRT_OFF_CNT_LO, 8'hF0);
      wrc(CRT_OFF_CTRL, 8'h05);
      repeat (300) @(posedge aclk);
      rdc(CRT_OFF_CTRL, 8'h85);
      rdc(CRT_OFF_CNT_HI, 8'h00);
      check("timer_req", 32'h1, {31'h0, timer_req});
      check("irq", 32'h0, {31'h0, irq});
      wrc(CRT_OFF_IRQ_MASK, 8'h03);
      check("irq", 32'h1, {31'h0, irq});
      rdc(CRT_OFF_IRQ_STAT, 8'h01);
      wrc(CRT_OFF_IRQ_STAT, 8'h01);
      check("irq", 32'h0, {31'h0, irq});
      wrc(CRT_OFF_CTRL, 8'h05);
      rdc(CRT_OFF_CTRL, 8'h05);
      check("timer_req", 32'h0, {31'h0, timer_req});
      // External events counted, then a capture by the trigger pin
      wrc(CRT_OFF_CTRL, 8'h0B);
      wrc(CRT_OFF_CNT_LO, 8'h00);
      wrc(CRT_OFF_CNT_HI, 8'h00);
      wrc(CRT_OFF_CTRL, 8'h0F);
      i_pins.pulse_count(5);
      repeat (30) @(posedge aclk);
      rdc(CRT_OFF_CNT_LO, 8'h05);
      i_pins.trig_fall();
      repeat (20) @(posedge aclk);
      rdc(CRT_OFF_CAP_LO, 8'h05);
      rdc(CRT_OFF_CAP_HI, 8'h00);
      rdc(CRT_OFF_CTRL, 8'h4F);
      rdc(CRT_OFF_IRQ_STAT, 8'h02);
      check("timer_req", 32'h1, {31'h0, timer_req});
      wrc(CRT_OFF_CTRL, 8'h00);
      wrc(CRT_OFF_IRQ_STAT, 8'h02);
      // Auto-reload: the count never leaves the reload window
      wrc(CRT_OFF_CAP_LO, 8'hF0);
      wrc(CRT_OFF_CAP_HI, 8'hFF);
      wrc(CRT_OFF_CNT_LO, 8'hF0);
      wrc(CRT_OFF_CNT_HI, 8'hFF);
      wrc(CRT_OFF_CTRL, 8'h04);
      repeat (250) @(posedge aclk);
      rdc(CRT_OFF_CNT_HI, 8'hFF);
      rdc(CRT_OFF_CTRL, 8'h84);
      // Trigger fall reloads the count from the capture bytes
      wrc(CRT_OFF_CTRL, 8'h00);
      wrc(CRT_OFF_CNT_HI, 8'h00);
      wrc(CRT_OFF_CTRL, 8'h0C);
      i_pins.trig_fall();
      repeat (20) @(posedge aclk);
      rdc(CRT_OFF_CNT_HI, 8'hFF);
      rdc(CRT_OFF_CTRL, 8'h4C);
      // Down counting selected by a low trigger level
      wrc(CRT_OFF_CTRL, 8'h00);
      wrc(CRT_OFF_MODE, 8'h01);
      i_pins.trig_level(1'b0);
      wrc(CRT_OFF_CAP_LO, 8'h00);
      wrc(CRT_OFF_CAP_HI, 8'h00);
      wrc(CRT_OFF_CNT_LO, 8'h80);
      wrc(CRT_OFF_CTRL, 8'h04);
      delta(8'hF6);
      wrc(CRT_OFF_CTRL, 8'h00);
      i_pins.trig_level(1'b1);
      // Clock output on the shared pin, period 4 x (65536 - 0xFFFE) cycles
      wrc(CRT_OFF_CAP_LO, 8'hFE);
      wrc(CRT_OFF_CAP_HI, 8'hFF);
      wrc(CRT_OFF_MODE, 8'h02);
      wrc(CRT_OFF_CTRL, 8'h04);
      check("clock_oe", 32'h1, {31'h0, count_pin_oe});
      @(posedge count_pin_o);
      r = cyc;
      @(posedge count_pin_o);
      check("clock_period", 32'h8, cyc - r);
      @(posedge aclk);
      rdc(CRT_OFF_CTRL, 8'h04);
      wrc(CRT_OFF_CTRL, 8'h14);
      repeat (100) @(posedge aclk);
      rdc(CRT_OFF_CTRL, 8'h14);
      finish_test();
   end
endmodule // tb_top
